// ===== rtl/l2_cfg_consts.svh
`ifndef L2_CFG_CONSTS_SVH
`define L2_CFG_CONSTS_SVH

// Byte offsets of the configuration table (upper main memory).
`define OFS_READ_ENABLE 8'hc2
`define OFS_PASSWORD_B3 8'hc3
`define OFS_PASSWORD_B2 8'hc4
`define OFS_PASSWORD_B1 8'hc5
`define OFS_PASSWORD_B0 8'hc6
`define OFS_TSEL_DEFAULT 8'hc7
`define OFS_SHUTDOWN_CFG 8'hda
`define OFS_TX_HIGH_LIMIT 8'hdb
`define OFS_TX_LOW_LIMIT 8'hdc
`define OFS_RX_ABSENT_LIMIT 8'hdd
// Table-select byte in lower main memory.
`define OFS_TABLE_SELECT 8'h7f

// Reset values.
`define RST_READ_ENABLE 8'h00
`define RST_PASSWORD 32'h0000_0000
`define RST_TSEL_DEFAULT 8'h01
`define RST_SHUTDOWN_CFG 8'h00
`define RST_TX_HIGH_LIMIT 8'hff
`define RST_TX_LOW_LIMIT 8'h00
`define RST_RX_ABSENT_LIMIT 8'h00

// Shutdown configuration field positions; bits 3:1 are unused and read zero.
`define SD_POLARITY_BIT 7
`define SD_TX_HIGH_EN_BIT 6
`define SD_BIAS_HIGH_EN_BIT 5
`define SD_TX_LOW_EN_BIT 4
`define SD_MASK_LOC_BIT 0
`define SD_WRITABLE_MASK 8'hf1

// Read-enable bit positions, one per protected block.
`define RE_T5_D0_D6 7
`define RE_T5_F8_FF 6
`define RE_CFG_80_C7 5
`define RE_T1_F8_FF 4
`define RE_T1_80_F7 3
`define RE_LOW_00_7A 2
`define RE_AUX_80_FF 1
`define RE_AUX_00_7F 0

// Table numbers.
`define TBL_00 8'h00
`define TBL_01 8'h01
`define TBL_02 8'h02
`define TBL_03 8'h03
`define TBL_04 8'h04
`define TBL_05 8'h05

// Block bounds.
`define ADR_T5_LO 8'hd0
`define ADR_T5_HI 8'hd6
`define ADR_F8 8'hf8
`define ADR_F7 8'hf7
`define ADR_80 8'h80
`define ADR_C7 8'hc7
`define ADR_7A 8'h7a
`define ADR_7F 8'h7f

`endif

// ===== rtl/l2_cfg_pkg.sv
package l2_cfg_pkg;

  typedef logic [7:0] cfg_byte_t;
  typedef logic [7:0] block_hits_t;

  typedef struct packed {
    logic polarity;
    logic tx_high_en;
    logic bias_high_en;
    logic tx_low_en;
    logic [2:0] unused;
    logic mask_loc;
  } shutdown_cfg_t;

endpackage : l2_cfg_pkg

// ===== rtl/prot_if.sv
`timescale 1ns/1ns
interface prot_if;
  import l2_cfg_pkg::*;
  logic aux;
  logic upper;
  logic alt_map;
  cfg_byte_t table_id;
  cfg_byte_t addr;
  block_hits_t hit;

  modport requester (output aux, output upper, output alt_map, output table_id,
                     output addr, input hit);
  modport decoder (input aux, input upper, input alt_map, input table_id,
                   input addr, output hit);
endinterface : prot_if

// ===== rtl/prot_block_decode.sv
`timescale 1ns/1ns
`include "l2_cfg_consts.svh"
// Maps one memory address onto the protected block it belongs to.
module prot_block_decode
  import l2_cfg_pkg::*;
(
  // Address to classify
  prot_if.decoder p
);
  cfg_byte_t cfg_table;
  cfg_byte_t user_table;
  logic main_up;

  always_comb begin
    cfg_table = p.alt_map ? `TBL_01 : `TBL_04;
    user_table = p.alt_map ? `TBL_00 : `TBL_01;
    main_up = !p.aux && p.upper;
    p.hit = '0;
    p.hit[`RE_T5_D0_D6] = main_up && p.table_id == `TBL_05 &&
                          p.addr >= `ADR_T5_LO && p.addr <= `ADR_T5_HI;
    p.hit[`RE_T5_F8_FF] = main_up && p.table_id == `TBL_05 && p.addr >= `ADR_F8;
    p.hit[`RE_CFG_80_C7] = main_up && (p.table_id == cfg_table ||
                           p.table_id == `TBL_02 || p.table_id == `TBL_03) &&
                           p.addr >= `ADR_80 && p.addr <= `ADR_C7;
    p.hit[`RE_T1_F8_FF] = main_up && p.table_id == user_table && p.addr >= `ADR_F8;
    p.hit[`RE_T1_80_F7] = main_up && p.table_id == user_table &&
                          p.addr >= `ADR_80 && p.addr <= `ADR_F7;
    p.hit[`RE_LOW_00_7A] = !p.aux && !p.upper && p.addr <= `ADR_7A;
    p.hit[`RE_AUX_80_FF] = p.aux && p.addr >= `ADR_80;
    p.hit[`RE_AUX_00_7F] = p.aux && p.addr <= `ADR_7F;
  end
endmodule : prot_block_decode

// ===== rtl/level2_protect_shutdown_config.sv
`timescale 1ns/1ns
`include "l2_cfg_consts.svh"
module level2_protect_shutdown_config
  import l2_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Memory map selection
  input wire logic alt_map,
  // Host byte access to main memory
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_upper,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_refused,
  // Password presented by the host
  input wire logic [31:0] entered_password,
  // Protection query from the rest of the memory
  input wire logic chk_aux,
  input wire logic chk_upper,
  input wire logic [7:0] chk_table,
  input wire logic [7:0] chk_addr,
  output logic chk_refused,
  // Measurements and alarms
  input wire logic [15:0] tx_power_meas,
  input wire logic [15:0] rssi_meas,
  input wire logic bias_high_alarm,
  output logic tx_power_high_alarm,
  output logic tx_power_low_alarm,
  output logic rx_signal_absent,
  // Shutdown and configuration outputs
  output logic laser_shutdown_output,
  output logic shutdown_active,
  output logic mask_in_user_table,
  output logic [7:0] table_select
);
  cfg_byte_t read_enable_q;
  logic [31:0] password_q;
  cfg_byte_t tsel_default_q;
  shutdown_cfg_t shutdown_cfg_q;
  cfg_byte_t tx_high_limit_q;
  cfg_byte_t tx_low_limit_q;
  cfg_byte_t rx_absent_limit_q;
  cfg_byte_t table_select_q;
  logic load_pending_q;
  logic shutdown_d;
  logic cfg_sel;
  logic pw_ok;
  logic own_refused;
  cfg_byte_t rdata_d;

  prot_if own_if ();
  prot_if ext_if ();

  // Classify host reads of this block and external queries.
  assign own_if.aux = 1'b0;
  assign own_if.upper = reg_upper;
  assign own_if.alt_map = alt_map;
  assign own_if.table_id = table_select_q;
  assign own_if.addr = reg_addr;
  assign ext_if.aux = chk_aux;
  assign ext_if.upper = chk_upper;
  assign ext_if.alt_map = alt_map;
  assign ext_if.table_id = chk_table;
  assign ext_if.addr = chk_addr;

  prot_block_decode own_dec (
    .p(own_if.decoder)
  );
  prot_block_decode ext_dec (
    .p(ext_if.decoder)
  );

  assign cfg_sel = reg_upper && table_select_q == (alt_map ? `TBL_01 : `TBL_04);
  assign pw_ok = entered_password == password_q;
  assign own_refused = |(own_if.hit & read_enable_q) && !pw_ok;

  always_ff @(posedge clk) begin
    if (reset) begin
      read_enable_q <= `RST_READ_ENABLE;
    end else if (reg_wr && cfg_sel && reg_addr == `OFS_READ_ENABLE) begin
      read_enable_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      password_q <= `RST_PASSWORD;
    end else if (reg_wr && cfg_sel) begin
      case (reg_addr)
        `OFS_PASSWORD_B3: begin
          password_q[31:24] <= reg_wdata;
        end
        `OFS_PASSWORD_B2: begin
          password_q[23:16] <= reg_wdata;
        end
        `OFS_PASSWORD_B1: begin
          password_q[15:8] <= reg_wdata;
        end
        `OFS_PASSWORD_B0: begin
          password_q[7:0] <= reg_wdata;
        end
        default: begin
          password_q <= password_q;
        end
      endcase
    end
  end

  // Configuration and threshold bytes; unused shutdown bits stay zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      tsel_default_q <= `RST_TSEL_DEFAULT;
      shutdown_cfg_q <= `RST_SHUTDOWN_CFG;
      tx_high_limit_q <= `RST_TX_HIGH_LIMIT;
      tx_low_limit_q <= `RST_TX_LOW_LIMIT;
      rx_absent_limit_q <= `RST_RX_ABSENT_LIMIT;
    end else if (reg_wr && cfg_sel) begin
      case (reg_addr)
        `OFS_TSEL_DEFAULT: begin
          tsel_default_q <= reg_wdata;
        end
        `OFS_SHUTDOWN_CFG: begin
          shutdown_cfg_q <= reg_wdata & `SD_WRITABLE_MASK;
        end
        `OFS_TX_HIGH_LIMIT: begin
          tx_high_limit_q <= reg_wdata;
        end
        `OFS_TX_LOW_LIMIT: begin
          tx_low_limit_q <= reg_wdata;
        end
        `OFS_RX_ABSENT_LIMIT: begin
          rx_absent_limit_q <= reg_wdata;
        end
        default: begin
          tsel_default_q <= tsel_default_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      load_pending_q <= 1'b1;
      table_select_q <= `RST_TSEL_DEFAULT;
    end else begin
      load_pending_q <= 1'b0;
      if (load_pending_q) begin
        table_select_q <= tsel_default_q;
      end else if (reg_wr && !reg_upper && reg_addr == `OFS_TABLE_SELECT) begin
        table_select_q <= reg_wdata;
      end
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (!reg_upper && reg_addr == `OFS_TABLE_SELECT) begin
      rdata_d = table_select_q;
    end else if (cfg_sel) begin
      case (reg_addr)
        `OFS_READ_ENABLE: rdata_d = read_enable_q;
        `OFS_PASSWORD_B3: rdata_d = password_q[31:24];
        `OFS_PASSWORD_B2: rdata_d = password_q[23:16];
        `OFS_PASSWORD_B1: rdata_d = password_q[15:8];
        `OFS_PASSWORD_B0: rdata_d = password_q[7:0];
        `OFS_TSEL_DEFAULT: rdata_d = tsel_default_q;
        `OFS_SHUTDOWN_CFG: rdata_d = shutdown_cfg_q;
        `OFS_TX_HIGH_LIMIT: rdata_d = tx_high_limit_q;
        `OFS_TX_LOW_LIMIT: rdata_d = tx_low_limit_q;
        `OFS_RX_ABSENT_LIMIT: rdata_d = rx_absent_limit_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rd_refused <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= own_refused ? 8'h00 : rdata_d;
      reg_rd_refused <= own_refused;
    end else begin
      reg_rd_refused <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chk_refused <= 1'b0;
    end else begin
      chk_refused <= |(ext_if.hit & read_enable_q) && !pw_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_power_high_alarm <= 1'b0;
      tx_power_low_alarm <= 1'b0;
      rx_signal_absent <= 1'b0;
    end else begin
      tx_power_high_alarm <= tx_power_meas[15:8] > tx_high_limit_q;
      tx_power_low_alarm <= tx_power_meas[15:8] < tx_low_limit_q;
      rx_signal_absent <= rssi_meas[15:8] < rx_absent_limit_q;
    end
  end

  assign shutdown_d = (shutdown_cfg_q.tx_high_en && tx_power_high_alarm) ||
                      (shutdown_cfg_q.bias_high_en && bias_high_alarm) ||
                      (shutdown_cfg_q.tx_low_en && tx_power_low_alarm);

  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown_active <= 1'b0;
      laser_shutdown_output <= 1'b1;
    end else begin
      shutdown_active <= shutdown_d;
      laser_shutdown_output <= shutdown_cfg_q.polarity ? shutdown_d : !shutdown_d;
    end
  end

  assign mask_in_user_table = shutdown_cfg_q.mask_loc;
  assign table_select = table_select_q;

  property p_rden_reset;
    @(posedge clk) reset |=> read_enable_q == 8'h00 && password_q == 32'h0;
  endproperty
  a_rden_reset: assert property (p_rden_reset) else $error("protect bytes not cleared");

  property p_t5_block;
    @(posedge clk) disable iff (reset)
      (!chk_aux && chk_upper && chk_table == 8'h05 && chk_addr >= 8'hd0 &&
       chk_addr <= 8'hd6 && read_enable_q[7] && !pw_ok) |=> chk_refused;
  endproperty
  a_t5_block: assert property (p_t5_block) else $error("table 05h block not guarded");

  property p_aux_low;
    @(posedge clk) disable iff (reset)
      (chk_aux && chk_addr[7] == 1'b0 && read_enable_q == 8'h01 && !pw_ok) |=> chk_refused;
  endproperty
  a_aux_low: assert property (p_aux_low) else $error("auxiliary low half not guarded");

  property p_pw_open;
    @(posedge clk) disable iff (reset) pw_ok |=> !chk_refused;
  endproperty
  a_pw_open: assert property (p_pw_open) else $error("refused despite password");

  property p_pw_byte;
    @(posedge clk) disable iff (reset)
      (reg_wr && cfg_sel && reg_addr == 8'hc3) |=> password_q[31:24] == $past(reg_wdata);
  endproperty
  a_pw_byte: assert property (p_pw_byte) else $error("password high byte not stored");

  property p_tsel_load;
    @(posedge clk) $fell(reset) |=> table_select_q == $past(tsel_default_q);
  endproperty
  a_tsel_load: assert property (p_tsel_load) else $error("table select not loaded");

  property p_polarity;
    @(posedge clk) disable iff (reset)
      !$past(reset) |-> laser_shutdown_output ==
        ($past(shutdown_cfg_q.polarity) ? shutdown_active : !shutdown_active);
  endproperty
  a_polarity: assert property (p_polarity) else $error("shutdown level wrong");

  property p_tx_high_trip;
    @(posedge clk) disable iff (reset)
      (tx_power_high_alarm && shutdown_cfg_q[6]) |=> shutdown_active;
  endproperty
  a_tx_high_trip: assert property (p_tx_high_trip) else $error("high power trip lost");

  property p_bias_trip;
    @(posedge clk) disable iff (reset)
      (bias_high_alarm && shutdown_cfg_q[5]) |=> shutdown_active;
  endproperty
  a_bias_trip: assert property (p_bias_trip) else $error("bias trip lost");

  property p_tx_low_trip;
    @(posedge clk) disable iff (reset)
      (tx_power_low_alarm && shutdown_cfg_q[4]) |=> shutdown_active;
  endproperty
  a_tx_low_trip: assert property (p_tx_low_trip) else $error("low power trip lost");

  property p_mask_loc;
    @(posedge clk) disable iff (reset)
      (reg_wr && cfg_sel && reg_addr == 8'hda) |=> mask_in_user_table == $past(reg_wdata[0]);
  endproperty
  a_mask_loc: assert property (p_mask_loc) else $error("mask location not stored");

  property p_high_cmp;
    @(posedge clk) disable iff (reset)
      (tx_power_meas[15:8] > tx_high_limit_q) |=> tx_power_high_alarm;
  endproperty
  a_high_cmp: assert property (p_high_cmp) else $error("high power compare wrong");

  property p_low_cmp;
    @(posedge clk) disable iff (reset)
      (tx_power_meas[15:8] < tx_low_limit_q) |=> tx_power_low_alarm;
  endproperty
  a_low_cmp: assert property (p_low_cmp) else $error("low power compare wrong");

  property p_absent_cmp;
    @(posedge clk) disable iff (reset)
      (rssi_meas[15:8] >= rx_absent_limit_q) |=> !rx_signal_absent;
  endproperty
  a_absent_cmp: assert property (p_absent_cmp) else $error("signal absent compare wrong");
endmodule : level2_protect_shutdown_config

// ===== verification/host_model.sv
`timescale 1ns/1ns
// Host side of the register port: one byte access per call, launched after a falling edge.
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_upper,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_refused,
  // Password presented by the host
  output logic [31:0] entered_password
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_upper = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    entered_password = 32'h0000_0000;
  end

  // Released address and data lines show the inverse of their last value.
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : release_bus

  task automatic wr(input logic up, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_upper = up;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    release_bus();
  endtask : wr

  task automatic rd(input logic up, input logic [7:0] a, output logic [7:0] d,
                    output logic refused);
    @(negedge clk);
    reg_upper = up;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    refused = reg_rd_refused;
    release_bus();
  endtask : rd

  task automatic set_pw(input logic [31:0] p);
    @(negedge clk);
    entered_password = p;
  endtask : set_pw
endmodule : host_model

// ===== verification/level2_protect_shutdown_config_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch at %0t got %h expected %h", $time, got, exp); \
    end \
  end
module level2_protect_shutdown_config_tb_top;
  import l2_cfg_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic alt_map = 1'b1;
  logic reg_wr, reg_rd, reg_upper, reg_rd_refused;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, table_select;
  logic [31:0] entered_password;
  logic chk_aux = 1'b0;
  logic chk_upper = 1'b0;
  logic [7:0] chk_table = 8'h00;
  logic [7:0] chk_addr = 8'h00;
  logic chk_refused;
  logic [15:0] tx_power_meas = 16'h0000;
  logic [15:0] rssi_meas = 16'h0000;
  logic bias_high_alarm = 1'b0;
  logic tx_power_high_alarm, tx_power_low_alarm, rx_signal_absent;
  logic laser_shutdown_output, shutdown_active, mask_in_user_table;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // One boundary address per protected block, indexed by read-enable bit: aux, upper, table, addr.
  localparam logic [17:0] blk [8] = '{{1'b1, 1'b0, 8'h00, 8'h7f}, {1'b1, 1'b0, 8'h00, 8'h80},
    {1'b0, 1'b0, 8'h00, 8'h7a}, {1'b0, 1'b1, 8'h01, 8'hf7}, {1'b0, 1'b1, 8'h01, 8'hff},
    {1'b0, 1'b1, 8'h02, 8'hc7}, {1'b0, 1'b1, 8'h05, 8'hf8}, {1'b0, 1'b1, 8'h05, 8'hd6}};

  always #4 clk = ~clk;

  level2_protect_shutdown_config i_level2_protect_shutdown_config (.clk(clk), .reset(reset),
    .alt_map(alt_map), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_upper(reg_upper),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_refused(reg_rd_refused), .entered_password(entered_password),
    .chk_aux(chk_aux), .chk_upper(chk_upper), .chk_table(chk_table), .chk_addr(chk_addr),
    .chk_refused(chk_refused), .tx_power_meas(tx_power_meas), .rssi_meas(rssi_meas),
    .bias_high_alarm(bias_high_alarm), .tx_power_high_alarm(tx_power_high_alarm),
    .tx_power_low_alarm(tx_power_low_alarm), .rx_signal_absent(rx_signal_absent),
    .laser_shutdown_output(laser_shutdown_output), .shutdown_active(shutdown_active),
    .mask_in_user_table(mask_in_user_table), .table_select(table_select));

  host_model i_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_upper(reg_upper), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_refused(reg_rd_refused),
    .entered_password(entered_password));

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic rd_chk(input logic up, input logic [7:0] a, input logic [7:0] exp,
                        input logic exp_ref);
    logic [7:0] d;
    logic r;
    i_host_model.rd(up, a, d, r);
    `CHK(d, exp)
    `CHK(r, exp_ref)
  endtask : rd_chk

  task automatic do_reset();
    @(negedge clk);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
  endtask : do_reset

  // After reset the table select points at the alternate config table.
  task automatic test_reset_values();
    `CHK(table_select, 8'h01)
    `CHK(laser_shutdown_output, 1'b1)
    rd_chk(1'b1, 8'hc2, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(1'b1, 8'hc3 + 8'(i), 8'h00, 1'b0);
    end
    rd_chk(1'b1, 8'hc7, 8'h01, 1'b0);
    rd_chk(1'b1, 8'hda, 8'h00, 1'b0);
    rd_chk(1'b1, 8'hdb, 8'hff, 1'b0);
    rd_chk(1'b1, 8'hdc, 8'h00, 1'b0);
    rd_chk(1'b1, 8'hdd, 8'h00, 1'b0);
    rd_chk(1'b1, 8'hc8, 8'h00, 1'b0);
    i_host_model.wr(1'b0, 8'h7f, 8'h04);
    `CHK(table_select, 8'h04)
    alt_map = 1'b0;
    rd_chk(1'b1, 8'hc7, 8'h01, 1'b0);
  endtask : test_reset_values

  task automatic test_password();
    for (int i = 0; i < 4; i++) begin
      i_host_model.wr(1'b1, 8'hc3 + 8'(i), 8'h12 + 8'(i) * 8'h22);
    end
    i_host_model.wr(1'b1, 8'hc2, 8'h20);
    rd_chk(1'b1, 8'hc3, 8'h00, 1'b1);
    i_host_model.set_pw(32'h1234_5678);
    rd_chk(1'b1, 8'hc3, 8'h12, 1'b0);
    rd_chk(1'b1, 8'hc6, 8'h78, 1'b0);
    rd_chk(1'b1, 8'hc2, 8'h20, 1'b0);
    i_host_model.set_pw(32'h1234_5670);
    rd_chk(1'b1, 8'hc6, 8'h00, 1'b1);
  endtask : test_password

  task automatic query(input logic [17:0] e, input logic exp);
    @(negedge clk);
    {chk_aux, chk_upper, chk_table, chk_addr} = e;
    @(negedge clk);
    `CHK(chk_refused, exp)
  endtask : query

  task automatic test_blocks();
    for (int i = 0; i < 8; i++) begin
      i_host_model.wr(1'b1, 8'hc2, 8'h01 << i);
      query(blk[i], 1'b1);
      i_host_model.wr(1'b1, 8'hc2, ~(8'h01 << i));
      query(blk[i], 1'b0);
    end
    i_host_model.wr(1'b1, 8'hc2, 8'h10);
    @(negedge clk);
    alt_map = 1'b1;
    query({1'b0, 1'b1, 8'h00, 8'hf8}, 1'b1);
    query({1'b0, 1'b1, 8'h01, 8'hf8}, 1'b0);
    @(negedge clk);
    alt_map = 1'b0;
    i_host_model.wr(1'b1, 8'hc2, 8'h00);
  endtask : test_blocks

  task automatic test_shutdown_cfg();
    i_host_model.wr(1'b1, 8'hda, 8'hff);
    rd_chk(1'b1, 8'hda, 8'hf1, 1'b0);
    `CHK(mask_in_user_table, 1'b1)
    i_host_model.wr(1'b1, 8'hda, 8'h00);
    `CHK(mask_in_user_table, 1'b0)
  endtask : test_shutdown_cfg

  // Expected e holds high, low, absent, shutdown and pin in that order.
  task automatic alarm_step(input logic [7:0] cfg, input logic [15:0] tx,
                            input logic [15:0] rx, input logic bias, input logic [4:0] e);
    i_host_model.wr(1'b1, 8'hda, cfg);
    @(negedge clk);
    tx_power_meas = tx;
    rssi_meas = rx;
    bias_high_alarm = bias;
    @(negedge clk);
    `CHK({tx_power_high_alarm, tx_power_low_alarm, rx_signal_absent}, e[4:2])
    @(negedge clk);
    `CHK({shutdown_active, laser_shutdown_output}, e[1:0])
  endtask : alarm_step

  task automatic test_alarms();
    i_host_model.wr(1'b1, 8'hdb, 8'h80);
    i_host_model.wr(1'b1, 8'hdc, 8'h40);
    i_host_model.wr(1'b1, 8'hdd, 8'h40);
    alarm_step(8'h40, 16'hff00, 16'hffff, 1'b0, 5'b10010);
    alarm_step(8'hc0, 16'hff00, 16'hffff, 1'b0, 5'b10011);
    alarm_step(8'h00, 16'hff00, 16'hffff, 1'b0, 5'b10001);
    alarm_step(8'h40, 16'h80ff, 16'h40ff, 1'b0, 5'b00001);
    alarm_step(8'h20, 16'h6000, 16'hffff, 1'b1, 5'b00010);
    alarm_step(8'h10, 16'h3fff, 16'h3fff, 1'b0, 5'b01110);
    alarm_step(8'h60, 16'h3fff, 16'h3fff, 1'b0, 5'b01101);
  endtask : test_alarms

  // A second reset in mid-run restores the defaults and reloads the table select.
  task automatic test_mid_reset();
    i_host_model.wr(1'b1, 8'hc7, 8'h05);
    do_reset();
    `CHK(table_select, 8'h01)
    @(negedge clk);
    `CHK(table_select, 8'h01)
    @(negedge clk);
    `CHK({tx_power_low_alarm, rx_signal_absent, laser_shutdown_output}, 3'b001)
    alt_map = 1'b1;
    rd_chk(1'b1, 8'hc7, 8'h01, 1'b0);
  endtask : test_mid_reset

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    test_reset_values();
    test_password();
    test_blocks();
    test_shutdown_cfg();
    test_alarms();
    test_mid_reset();
    final_report();
  end
endmodule : level2_protect_shutdown_config_tb_top
